// ==== common/pfc_defines.vh ====
// Purpose: Constants for the flow-control credit block
// Assumes: 100 MHz core clock
// Notes: Class indices follow the order P, NP, CPL, header then data
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
`define PFC_NUM_CLASS 6
`define PFC_CLS_PH 3'h0
`define PFC_CLS_PD 3'h1
`define PFC_CLS_NPH 3'h2
`define PFC_CLS_NPD 3'h3
`define PFC_CLS_CPLH 3'h4
`define PFC_CLS_CPLD 3'h5
`define PFC_HDR_COST 12'h001
`define PFC_UPD_TIME_NS 30000
`define PFC_CLK_PERIOD_NS 10
`define PFC_UPD_CYCLES (`PFC_UPD_TIME_NS / `PFC_CLK_PERIOD_NS)
`define PFC_QUARTER_SHIFT 2
`define PFC_RCB_BYTES 64
`define PFC_TAGS_SMALL 7'h20
`define PFC_TAGS_LARGE 7'h40
`endif

// ==== core/pfc_class_rx.v ====
// Purpose: Receive-side credit allocation and update scheduling, one class
// Assumes: Inputs come from logic on the same clock
// Notes: All credit arithmetic wraps at the counter width
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_class_rx #(
	parameter W = 12,
	parameter [W-1:0] TOTAL = 12'h040,
	parameter [W-1:0] MAX_PAYLOAD = 12'h010,
	parameter TIMER_CYCLES = 3000,
	parameter INFINITE = 0
) (
	input wire clk, // Core clock
	input wire reset, // Synchronous reset
	input wire drain_done, // Packet fully drained from buffer
	input wire [W-1:0] drain_cred, // Credits that packet used
	input wire recv_pkt, // Packet received into buffer
	input wire [W-1:0] recv_cred, // Credits of received packet
	input wire upd_sent, // Update for this class went out
	output reg [W-1:0] alloc_r, // Current allocated counter
	output wire upd_pend, // Allocation ahead of advertised, or timer expired
	output wire upd_hi // High-priority request
);
	reg [W-1:0] adv_r;
	reg [W-1:0] rcvd_r;
	reg [31:0] tmr_r;
	reg tmo_r;
	wire [W-1:0] ahead = alloc_r - adv_r;
	wire [W-1:0] left = adv_r - rcvd_r;
	wire starve = (left < MAX_PAYLOAD) && (ahead != {W{1'b0}});
	wire quarter = ahead >= (TOTAL >> `PFC_QUARTER_SHIFT);
	assign upd_pend = (INFINITE == 0) && (ahead != {W{1'b0}} || tmo_r);
	assign upd_hi = upd_pend && (starve || tmo_r || quarter);

	always @(posedge clk)
	begin
		if (reset)
		begin
			alloc_r <= TOTAL;
			adv_r <= TOTAL;
			rcvd_r <= {W{1'b0}};
			tmr_r <= 32'h0;
			tmo_r <= 1'b0;
		end
		else
		begin
			if (drain_done && INFINITE == 0)
				alloc_r <= alloc_r + drain_cred;
			if (recv_pkt)
				rcvd_r <= rcvd_r + recv_cred;
			if (upd_sent)
			begin
				adv_r <= alloc_r;
				tmr_r <= 32'h0;
				tmo_r <= 1'b0;
			end
			else if (tmr_r >= TIMER_CYCLES - 1)
				tmo_r <= (INFINITE == 0);
			else
				tmr_r <= tmr_r + 32'h1;
		end
	end
endmodule // pfc_class_rx

// ==== core/pfc_credit_ctl.v ====
// Purpose: Credit-based flow control for a link-layer port
// Assumes: Single clock; link partner logic on the same clock
// Notes: Classes ordered P hdr, P data, NP hdr, NP data, CPL hdr, CPL data
// Summary of operation
// - Separate limit and consumed counters per class
// - Limits load at init, then from updates
// - Send when limit minus consumed covers need
// - Header and data checked apart; one header
// - Charge consumed counters when packet selected
// - Allocated counters start at buffer free space
// - Allocation grows only after full drain
// - Update carries current allocated value
// - Updates default to low link priority
// - Starving partner raises update priority
// - Thirty microsecond timer raises priority
// - Quarter of buffer ahead raises priority
// - Update never interrupts packet on link
// - Received update refreshes limit, frees stalls
// - Endpoint advertises infinite completion credits
// - Completion headers sized by 64-byte boundary
// - Outstanding tags limited to 32 or 64
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_credit_ctl #(
	parameter W = 12,
	parameter [W-1:0] PH_TOTAL = 12'h020,
	parameter [W-1:0] PD_TOTAL = 12'h100,
	parameter [W-1:0] NPH_TOTAL = 12'h020,
	parameter [W-1:0] NPD_TOTAL = 12'h020,
	parameter CPLD_BYTES = 8192,
	parameter [W-1:0] MAX_PAYLOAD = 12'h010,
	parameter TIMER_CYCLES = `PFC_UPD_CYCLES
) (
	input wire clk, // Core clock, 100 MHz
	input wire reset, // Synchronous reset, active high
	// Transmit side
	input wire tx_req, // Application has a packet pending
	input wire [1:0] tx_type, // 0 posted, 1 non-posted, 2 completion
	input wire [W-1:0] tx_data_cred, // Data credits needed
	input wire tx_has_tag, // Packet consumes a request tag
	output wire tx_grant, // Packet selected for link
	output wire tx_stall, // Packet held for credits, tags or type 3
	input wire tx_busy, // Packet currently on the link
	// Credit limits from partner
	input wire fc_init, // Init-phase limit load
	input wire fc_upd, // Received update DLLP
	input wire [2:0] fc_class, // Class of init or update
	input wire [W-1:0] fc_value, // Limit carried
	input wire [5:0] fc_inf, // Class advertised infinite
	// Receive side
	input wire rx_recv, // Packet placed into buffer
	input wire [1:0] rx_type, // Type of received packet
	input wire [W-1:0] rx_data_cred, // Its data credits
	input wire rx_drain, // Application finished draining packet
	input wire [1:0] rx_drain_type, // Type of drained packet
	input wire [W-1:0] rx_drain_cred, // Its data credits
	// Update DLLP out
	input wire other_req, // Other traffic wants the link
	output wire upd_valid, // Update DLLP request
	output wire upd_high, // Request is high priority
	output reg [2:0] upd_class_r, // Class of update
	output reg [W-1:0] upd_value_r, // Allocated value carried
	input wire upd_ack, // Update DLLP taken by link
	// Tags
	input wire tags_large, // Allow 64 tags rather than 32
	input wire tag_done, // Completion retired a tag
	output reg [6:0] tags_used_r, // Tags outstanding
	output wire [W-1:0] cplh_adv // Completion header sizing
);
	localparam integer CPLH_INT = CPLD_BYTES / `PFC_RCB_BYTES;
	localparam integer CPLD_INT = CPLD_BYTES / 16;
	localparam [W-1:0] CPLH_TOTAL = CPLH_INT[W-1:0];
	localparam [W-1:0] CPLD_TOTAL = CPLD_INT[W-1:0];
	localparam [W-1:0] HDR = `PFC_HDR_COST;

	// ==========================================
	// Transmit limit and consumed counters
	wire [W-1:0] limit_r [0:5];
	wire [W-1:0] used_r [0:5];
	wire [5:0] inf_r;
	wire [2:0] hc = {tx_type, 1'b0};
	wire [2:0] dc = {tx_type, 1'b1};
	wire [W-1:0] h_room = limit_r[hc] - used_r[hc];
	wire [W-1:0] d_room = limit_r[dc] - used_r[dc];
	wire h_ok = inf_r[hc] || (h_room >= HDR);
	wire d_ok = inf_r[dc] || (d_room >= tx_data_cred);
	wire [6:0] tag_max = tags_large ? `PFC_TAGS_LARGE : `PFC_TAGS_SMALL;
	wire tag_ok = !tx_has_tag || (tags_used_r < tag_max);
	wire tx_ok = tx_req && h_ok && d_ok && tag_ok && tx_type != 2'h3;
	reg upd_win;
	assign tx_grant = tx_ok && !tx_busy && !upd_win;
	assign tx_stall = tx_req && !tx_ok;

	genvar g;
	generate
		for (g = 0; g < `PFC_NUM_CLASS; g = g + 1)
		begin : g_tx
			reg [W-1:0] lim_r;
			reg [W-1:0] use_r;
			reg inf_q_r;
			assign limit_r[g] = lim_r;
			assign used_r[g] = use_r;
			assign inf_r[g] = inf_q_r;
			always @(posedge clk)
			begin
				if (reset)
				begin
					lim_r <= {W{1'b0}};
					use_r <= {W{1'b0}};
					inf_q_r <= 1'b0;
				end
				else
				begin
					if ((fc_init || fc_upd) && fc_class == g)
					begin
						lim_r <= fc_value;
						if (fc_init)
							inf_q_r <= fc_inf[g];
					end
					if (tx_grant && hc == g)
						use_r <= use_r + HDR;
					else if (tx_grant && dc == g)
						use_r <= use_r + tx_data_cred;
				end
			end
		end
	endgenerate

	// ==========================================
	// Tag accounting
	always @(posedge clk)
	begin
		if (reset)
			tags_used_r <= 7'h00;
		else if ((tx_grant && tx_has_tag) && !tag_done)
			tags_used_r <= tags_used_r + 7'h01;
		else if (!(tx_grant && tx_has_tag) && tag_done
			&& tags_used_r != 7'h00)
			tags_used_r <= tags_used_r - 7'h01;
	end

	// ==========================================
	// Receive allocation per class
	wire [W-1:0] alloc [0:5];
	wire [5:0] pend;
	wire [5:0] hi;
	wire [5:0] sent;
	wire [W-1:0] tot [0:5];
	assign tot[0] = PH_TOTAL;
	assign tot[1] = PD_TOTAL;
	assign tot[2] = NPH_TOTAL;
	assign tot[3] = NPD_TOTAL;
	assign tot[4] = CPLH_TOTAL;
	assign tot[5] = CPLD_TOTAL;
	assign cplh_adv = CPLH_TOTAL;

	generate
		for (g = 0; g < `PFC_NUM_CLASS; g = g + 1)
		begin : g_rx
			localparam HDRC = (g % 2) == 0;
			localparam integer TYI = g / 2;
			localparam [1:0] TY = TYI[1:0];
			localparam [W-1:0] TOTG = (g == 0) ? PH_TOTAL :
				(g == 1) ? PD_TOTAL : (g == 2) ? NPH_TOTAL :
				(g == 3) ? NPD_TOTAL : (g == 4) ? CPLH_TOTAL : CPLD_TOTAL;
			pfc_class_rx #(
				.W(W),
				.TOTAL(TOTG),
				.MAX_PAYLOAD(HDRC ? HDR : MAX_PAYLOAD),
				.TIMER_CYCLES(TIMER_CYCLES),
				.INFINITE(g >= 4)
			) u_rx (
				.clk(clk),
				.reset(reset),
				.drain_done(rx_drain && rx_drain_type == TY),
				.drain_cred(HDRC ? HDR : rx_drain_cred),
				.recv_pkt(rx_recv && rx_type == TY),
				.recv_cred(HDRC ? HDR : rx_data_cred),
				.upd_sent(sent[g]),
				.alloc_r(alloc[g]),
				.upd_pend(pend[g]),
				.upd_hi(hi[g])
			);
		end
	endgenerate

	// ==========================================
	// Update selection and link arbitration
	reg [2:0] sel;
	reg sel_hi;
	reg sel_any;
	integer i;
	always @*
	begin
		sel = 3'h0;
		sel_hi = 1'b0;
		sel_any = 1'b0;
		for (i = `PFC_NUM_CLASS - 1; i >= 0; i = i - 1)
		begin
			if (pend[i] && (hi[i] || !sel_hi))
			begin
				sel = i[2:0];
				sel_hi = hi[i];
				sel_any = 1'b1;
			end
		end
	end

	reg upd_v_r;
	reg upd_h_r;
	always @*
	begin
		// Low priority yields to packets and other DLLPs
		upd_win = upd_v_r && (upd_h_r || (!tx_ok && !other_req));
	end
	// Held off while a packet is already on the link
	assign upd_valid = upd_v_r && upd_win && !tx_busy;
	assign upd_high = upd_h_r;
	assign sent = (upd_valid && upd_ack) ?
		(6'h01 << upd_class_r) : 6'h00;

	always @(posedge clk)
	begin
		if (reset)
		begin
			upd_v_r <= 1'b0;
			upd_h_r <= 1'b0;
			upd_class_r <= 3'h0;
			upd_value_r <= {W{1'b0}};
		end
		else if (!upd_v_r || (upd_valid && upd_ack))
		begin
			upd_v_r <= sel_any && !(upd_valid && upd_ack);
			upd_h_r <= sel_hi;
			upd_class_r <= sel;
			upd_value_r <= alloc[sel];
		end
		else
		begin
			upd_h_r <= upd_h_r || hi[upd_class_r];
			upd_value_r <= alloc[upd_class_r];
		end
	end
endmodule // pfc_credit_ctl

// ==== dv/pfc_credit_ctl_checker.sv ====
// Purpose: Port checker for the credit block
// Assumes: Bound into every instance
// Notes: Values of updates are judged by the bench
`timescale 1ns/100ps
module pfc_credit_ctl_checker #(
	parameter W = 12,
	parameter CPLD_BYTES = 8192
) (
	input wire clk, // Clock
	input wire reset, // Reset
	input wire tx_req, // Pending
	input wire [1:0] tx_type, // Type
	input wire tx_has_tag, // Tagged
	input wire tx_grant, // Grant
	input wire tx_stall, // Held
	input wire tx_busy, // Link busy
	input wire upd_valid, // Update req
	input wire upd_ack, // Update taken
	input wire [2:0] upd_class_r, // Class
	input wire tags_large, // 64 tags
	input wire tag_done, // Tag retired
	input wire [6:0] tags_used_r, // Tags out
	input wire [W-1:0] cplh_adv // Cpl headers
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	property p_grant; tx_grant |-> tx_req && !tx_stall; endproperty
	a_grant: assert property (p_grant) else $error("bad grant");
	property p_type; tx_req && tx_type == 2'h3 |-> !tx_grant; endproperty
	a_type: assert property (p_type) else $error("bad type");
	property p_busy; tx_busy |-> !tx_grant; endproperty
	a_busy: assert property (p_busy) else $error("grant on busy");
	property p_cplh; cplh_adv == W'(CPLD_BYTES / 64); endproperty
	a_cplh: assert property (p_cplh) else $error("cpl size");
	property p_cap; tx_req && tx_has_tag &&
		tags_used_r == (tags_large ? 7'h40 : 7'h20) |-> !tx_grant; endproperty
	a_cap: assert property (p_cap) else $error("tag cap");
	property p_inc; tx_grant && tx_has_tag && !tag_done
		|=> tags_used_r == $past(tags_used_r) + 7'h1; endproperty
	a_inc: assert property (p_inc) else $error("tag count");
	property p_cpl; upd_valid |-> upd_class_r < 3'h4; endproperty
	a_cpl: assert property (p_cpl) else $error("cpl update");
	property p_rst; $fell(reset) |-> tags_used_r == 7'h0 && !upd_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
endmodule // pfc_credit_ctl_checker
bind pfc_credit_ctl pfc_credit_ctl_checker #(.W(W),
	.CPLD_BYTES(CPLD_BYTES)) u_chk (.*);

// ==== dv/pfc_credit_ctl_tb_top.sv ====
// Purpose: Bench for the credit block
// Assumes: Link model takes updates
// Notes: Random data from xorshift
`timescale 1ns/100ps
`define CHK(a,b) begin n_tests++; if ((a)!==(b)) begin error_cnt++; \
$display("unexpected %0t mismatch %h", $time, a); end end
module pfc_credit_ctl_tb_top;
	logic clk=0,reset=1,tx_req=0,tx_has_tag=0,tx_busy=0,fc_init=0,fc_upd=0;
	logic rx_recv=0,rx_drain=0,other_req=0,tags_large=0,tag_done=0,slow=0;
	logic [1:0] tx_type=0,rx_type=0,rx_drain_type=0;
	logic [2:0] fc_class=0,upd_class_r;
	logic [5:0] fc_inf=6'h30;
	logic [11:0] tx_data_cred=0,fc_value=0,rx_data_cred=0,rx_drain_cred=0;
	logic [11:0] upd_value_r,cplh_adv,ex[4]='{12'h20,12'h100,12'h20,12'h20};
	logic [6:0] tags_used_r;
	logic tx_grant,tx_stall,upd_valid,upd_high,upd_ack;
	logic [31:0] rs=32'h42;
	int error_cnt=0,n_tests=0,nupd=0;
	pfc_credit_ctl #(.TIMER_CYCLES(20)) u_pfc_credit_ctl (.*);
	pfc_link_model u_pfc_link_model (.*);
	initial forever #5 clk=~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s^=s<<13;
		s^=s>>17;
		return s^(s<<5);
	endfunction
	task automatic fc(input logic u,input logic [2:0] c,input logic [11:0] v);
		@(posedge clk);
		fc_init<=!u;
		fc_upd<=u;
		fc_class<=c;
		fc_value<=v;
		@(posedge clk);
		fc_init<=0;
		fc_upd<=0;
	endtask
	task automatic send(input logic [1:0] t,input logic [11:0] d,
		input logic tg,input logic g);
		@(posedge clk);
		tx_req<=1;
		tx_type<=t;
		tx_data_cred<=d;
		tx_has_tag<=tg;
		@(negedge clk);
		// A high-priority update owns the link first
		while (upd_valid && upd_high)
			@(negedge clk);
		`CHK(tx_grant,g)
		@(posedge clk);
		tx_req<=0;
	endtask
	task automatic report_and_stop;
		$display("tests %0d errors %0d",n_tests,error_cnt);
		if (error_cnt==0 && n_tests>0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(negedge clk)
		if (upd_valid && upd_ack)
		begin
			nupd++;
			`CHK(upd_value_r,ex[upd_class_r[1:0]])
		end
	// Run is some 450 cycles; far beyond that means a hang
	initial
	begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	initial
	begin
		repeat (6) @(posedge clk);
		reset<=0;
		fc(0,0,12'h002);
		fc(0,1,12'h008);
		fc(0,2,12'h040);
		fc(0,3,12'hfff);
		fc(0,4,12'h000);
		fc(0,5,12'h000);
		send(0,12'h004,0,1);
		send(0,12'h005,0,0);
		send(0,12'h004,0,1);
		send(0,12'h000,0,0);
		send(3,12'h000,0,0);
		fc(1,0,12'h004);
		tx_busy<=1;
		send(0,12'h000,0,0);
		tx_busy<=0;
		send(0,12'h000,0,1);
		$display("test credits done");
		repeat (32)
		begin
			rs=xs(rs);
			send(1,{9'h0,rs[2:0]},1,1);
		end
		send(1,12'h000,1,0);
		tags_large<=1;
		send(1,12'h000,1,1);
		@(negedge clk);
		`CHK(tags_used_r,7'h21)
		@(posedge clk);
		tag_done<=1;
		@(posedge clk);
		tag_done<=0;
		@(negedge clk);
		`CHK(tags_used_r,7'h20)
		$display("test tags done");
		repeat (7)
		begin
			rs=xs(rs);
			if (nupd==6)
				other_req<=1;
			@(posedge clk);
			slow<=rs[9];
			rx_drain<=1;
			rx_recv<=1;
			rx_drain_type<={1'h0,rs[0]};
			rx_type<={1'h0,rs[0]};
			rx_drain_cred<={4'h0,rs[15:8]};
			rx_data_cred<={4'h0,rs[15:8]};
			@(posedge clk);
			rx_drain<=0;
			rx_recv<=0;
			// Carried value follows allocation one edge later
			@(posedge clk);
			ex[{rs[0],1'h0}]+=12'h1;
			ex[{rs[0],1'h1}]+={4'h0,rs[15:8]};
			repeat (44) @(posedge clk);
		end
		`CHK(nupd>=7,1'h1)
		$display("test updates done");
		report_and_stop();
	end
endmodule // pfc_credit_ctl_tb_top

// ==== dv/pfc_link_model.sv ====
// Purpose: Far port taking update DLLPs
// Assumes: Same clock as the block
// Notes: Slow mode waits before taking
`timescale 1ns/100ps
module pfc_link_model (
	input wire logic clk, // Clock
	input wire logic reset, // Reset
	input wire logic upd_valid, // Offered
	input wire logic slow, // Take late
	output logic upd_ack // Taken
);
	logic [1:0] wait_r;
	always @(posedge clk)
		if (reset || !upd_valid || upd_ack)
		begin
			wait_r <= 2'h0;
			upd_ack <= 1'h0;
		end
		else if (!slow || wait_r == 2'h3)
			upd_ack <= 1'h1;
		else
			wait_r <= wait_r + 2'h1;
endmodule // pfc_link_model
